// ===== hw/sleep_ctrl.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sleep_consts.svh"
// What this block does
// - Mode 01 gates io, cpu, flash clocks
// - Noise mode keeps converter, irq, watchdog if enabled
// - Noise mode entry starts conversion automatically
// - Noise mode wake sources limited to listed events
// - Mode 10 stops oscillator and all clocks
// - Power-down wakes only on reset, level, pinchange, watchdog irq
// - External irq zero wakes only when level
// - Enabled converter stays enabled in sleep
// - Converter re-enable makes next conversion extended
// - Power-down disables comparator; reference stays if used
// - Enabled brown-out detector stays on in sleep
// - Reference on only when a user needs it
// - Enabled watchdog stays enabled in sleep
// - Input buffers off when io and converter stopped
// - Wake-detect pin inputs stay enabled
// - Disable register bit turns pin buffer off
// - Sleep only when arm bit set
// - Mode 00 idles: only cpu, flash stop
// - Wake stalls four cycles, plus start-up cycles from power-down
// - Reset during sleep restarts from reset vector
module sleep_ctrl
    import sleep_pkg::*;
#(
    parameter int PINS = `PIN_COUNT,
    parameter int STARTUP_CYC = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // CPU side
    input wire logic sleep_instr,
    output logic cpu_resume,
    output logic reset_vector_go,
    // Wake and reset sources, from pins or other clocks
    input wire logic ext_irq_zero,
    input wire logic [PINS-1:0] pin_change_mask,
    input wire logic [PINS-1:0] pin_in,
    input wire logic ext_reset_req,
    input wire logic wdog_reset_req,
    input wire logic bod_reset_req,
    // Wake sources from on-chip logic
    input wire logic conv_done_irq,
    input wire logic nvm_ready_irq,
    input wire logic timer_irq,
    input wire logic cmp_irq,
    input wire logic wdog_irq,
    // Fuses
    input wire logic [1:0] brownout_level_fuses,
    // Clock gates
    output logic clk_cpu_en,
    output logic clk_flash_en,
    output logic clk_io_en,
    output logic clk_conv_en,
    output logic osc_en,
    // Peripheral enables
    output logic conv_en,
    output logic conv_start,
    output logic conv_extended,
    output logic cmp_en,
    output logic vref_en,
    output logic brownout_detector_en,
    output logic wdog_en,
    output logic ext_irq_en,
    output logic [PINS-1:0] in_buf_en
);
    // ======================================================================
    // Registers and state
    logic [7:0] mcu_control_reg_r;
    logic [7:0] digital_input_disable_reg_r;
    logic [7:0] periph_r;
    logic [7:0] wake_cause_r;
    sleep_state_e state_r;
    mode_t mode_r;
    logic [7:0] stall_cnt_r;
    logic conv_was_off_r;
    logic [PINS-1:0] pin_prev_r;
    logic wake_is_reset_r;

    // ======================================================================
    // Synchronised pin-level inputs
    logic irq0_s;
    logic [PINS-1:0] pin_s;
    logic [2:0] rst_s;

    sync3 #(.W(1)) u_sync_irq (
        .core_clk(core_clk),
        .rstn(rstn),
        .din(ext_irq_zero),
        .dout(irq0_s)
    );

    sync3 #(.W(PINS + 3)) u_sync_pins (
        .core_clk(core_clk),
        .rstn(rstn),
        .din({pin_in, ext_reset_req, wdog_reset_req, bod_reset_req}),
        .dout({pin_s, rst_s})
    );

    // ======================================================================
    // Decode helpers
    function automatic logic level_cfg(input logic [7:0] ctl);
        level_cfg = ctl[`MCU_ISC_HI:`MCU_ISC_LO] == `ISC_LEVEL;
    endfunction : level_cfg

    logic [1:0] sel_mode;
    logic asleep;
    logic is_noise;
    logic is_pdown;
    logic reset_wake;
    logic pc_event;
    logic level_wake;
    logic irq_wake;
    logic bod_on;
    logic [7:0] stall_len;

    assign sel_mode = mcu_control_reg_r[`MCU_MODE_HI:`MCU_MODE_LO];
    assign asleep = state_r == ST_SLEEP;
    assign is_noise = asleep && mode_r == `MODE_NOISE;
    assign is_pdown = asleep && mode_r == `MODE_PDOWN;
    assign bod_on = brownout_level_fuses != 2'h3;
    assign reset_wake = |rst_s;
    // Pin change seen only on pins the change mask selects
    assign pc_event = |((pin_s ^ pin_prev_r) & pin_change_mask);
    // Low level on irq zero wakes, edges never do
    assign level_wake = level_cfg(mcu_control_reg_r) && !irq0_s;
    assign stall_len = 8'(`WAKE_STALL_CYC + STARTUP_CYC);

    // Wake qualification per mode
    always_comb begin
        irq_wake = 1'b0;
        unique case (mode_r)
            `MODE_IDLE: begin
                irq_wake = level_wake || pc_event || conv_done_irq ||
                    nvm_ready_irq || timer_irq || cmp_irq || wdog_irq;
            end
            `MODE_NOISE: begin
                irq_wake = level_wake || pc_event || conv_done_irq ||
                    nvm_ready_irq || wdog_irq;
            end
            `MODE_PDOWN: begin
                irq_wake = level_wake || pc_event || wdog_irq;
            end
            default: begin
                irq_wake = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // Register writes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mcu_control_reg_r <= `RST_MCU_CTRL;
            digital_input_disable_reg_r <= `RST_DIG_DIS;
            periph_r <= `RST_PERIPH;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFF_MCU_CTRL: mcu_control_reg_r <= reg_wdata & `MCU_CTRL_MASK;
                `OFF_DIG_DIS: digital_input_disable_reg_r <= reg_wdata;
                `OFF_PERIPH: periph_r <= reg_wdata & 8'h0F;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFF_MCU_CTRL: reg_rdata <= mcu_control_reg_r;
                `OFF_DIG_DIS: reg_rdata <= digital_input_disable_reg_r;
                `OFF_PERIPH: reg_rdata <= periph_r;
                `OFF_STATUS: reg_rdata <= {4'h0, conv_extended, vref_en,
                    state_r};
                `OFF_WAKE_CAUSE: reg_rdata <= wake_cause_r;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ======================================================================
    // Sleep state machine
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_RUN;
            mode_r <= `MODE_IDLE;
            stall_cnt_r <= 8'h00;
            wake_is_reset_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    // Reserved mode 11 is treated as no sleep
                    if (sleep_instr && mcu_control_reg_r[`MCU_ARM_BIT] &&
                        sel_mode != 2'h3) begin
                        state_r <= ST_SLEEP;
                        mode_r <= sel_mode;
                    end
                end
                ST_SLEEP: begin
                    if (reset_wake || irq_wake) begin
                        state_r <= ST_STALL;
                        wake_is_reset_r <= reset_wake;
                        // Only power-down needs oscillator start-up
                        stall_cnt_r <= (mode_r == `MODE_PDOWN) ? stall_len :
                            8'(`WAKE_STALL_CYC);
                    end
                end
                ST_STALL: begin
                    // Pulse lands in the first run cycle after the last counted stall cycle
                    if (stall_cnt_r <= 8'h01) begin
                        state_r <= ST_RUN;
                        stall_cnt_r <= 8'h00;
                    end else begin
                        stall_cnt_r <= stall_cnt_r - 8'h01;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    // Wake cause capture and pin history
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wake_cause_r <= 8'h00;
            pin_prev_r <= '0;
        end else begin
            pin_prev_r <= pin_s;
            if (asleep && (reset_wake || irq_wake)) begin
                wake_cause_r <= {1'b0, pc_event, level_wake, conv_done_irq,
                    nvm_ready_irq, wdog_irq, reset_wake, 1'b1};
            end
        end
    end

    // CPU resume or reset-vector pulses at the end of the stall
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_resume <= 1'b0;
            reset_vector_go <= 1'b0;
        end else begin
            cpu_resume <= 1'b0;
            reset_vector_go <= 1'b0;
            if (state_r == ST_STALL && stall_cnt_r <= 8'h01) begin
                cpu_resume <= !wake_is_reset_r;
                reset_vector_go <= wake_is_reset_r;
            end
        end
    end

    // ======================================================================
    // Clock gating; stall runs all clocks, oscillator included, as in run
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clk_cpu_en <= 1'b1;
            clk_flash_en <= 1'b1;
            clk_io_en <= 1'b1;
            clk_conv_en <= 1'b1;
            osc_en <= 1'b1;
        end else begin
            clk_cpu_en <= !asleep;
            clk_flash_en <= !asleep;
            clk_io_en <= !(is_noise || is_pdown);
            clk_conv_en <= !is_pdown;
            osc_en <= !is_pdown;
        end
    end

    // ======================================================================
    // Peripheral enables follow software or fuses, irq enable tied high; only the comparator is gated by sleep mode
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            conv_en <= 1'b0;
            cmp_en <= 1'b0;
            vref_en <= 1'b0;
            brownout_detector_en <= 1'b0;
            wdog_en <= 1'b0;
            ext_irq_en <= 1'b0;
        end else begin
            conv_en <= periph_r[`PER_CONV_EN];
            // Comparator forced off in power-down, whatever software says
            cmp_en <= periph_r[`PER_CMP_EN] && !is_pdown;
            brownout_detector_en <= bod_on;
            // Ref stays up while a comparator selects it, even asleep
            vref_en <= bod_on || periph_r[`PER_CONV_EN] ||
                (periph_r[`PER_CMP_EN] && periph_r[`PER_CMP_REF]);
            wdog_en <= periph_r[`PER_WDOG_EN];
            // Level detect is asynchronous, so it keeps power in every mode
            ext_irq_en <= 1'b1;
        end
    end

    // Auto conversion on noise-mode entry and extended-conversion tracking
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            conv_start <= 1'b0;
            conv_extended <= 1'b1;
            conv_was_off_r <= 1'b1;
        end else begin
            conv_start <= state_r == ST_RUN && sleep_instr &&
                mcu_control_reg_r[`MCU_ARM_BIT] &&
                sel_mode == `MODE_NOISE && periph_r[`PER_CONV_EN];
            if (!periph_r[`PER_CONV_EN]) begin
                conv_was_off_r <= 1'b1;
            end else if (conv_start) begin
                conv_was_off_r <= 1'b0;
            end
            conv_extended <= conv_was_off_r && periph_r[`PER_CONV_EN];
        end
    end

    // ======================================================================
    // Input buffers: software disable, sleep gating, wake pins kept
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            in_buf_en <= '1;
        end else begin
            // Pin one carries irq zero; kept only while it can level-wake
            for (int i = 0; i < PINS; i++) begin
                in_buf_en[i] <= !digital_input_disable_reg_r[i] &&
                    (!is_pdown || pin_change_mask[i] ||
                    (i == 1 && level_cfg(mcu_control_reg_r)));
            end
        end
    end
endmodule : sleep_ctrl

// ===== hw/sleep_consts.svh
`ifndef SLEEP_CONSTS_SVH
`define SLEEP_CONSTS_SVH

// ==========================================================================
// Register offsets
`define OFF_MCU_CTRL 4'h0
`define OFF_DIG_DIS 4'h1
`define OFF_PERIPH 4'h2
`define OFF_STATUS 4'h3
`define OFF_WAKE_CAUSE 4'h4

// ==========================================================================
// Control register field positions
`define MCU_ARM_BIT 5
`define MCU_MODE_HI 4
`define MCU_MODE_LO 3
`define MCU_ISC_HI 1
`define MCU_ISC_LO 0
`define MCU_CTRL_MASK 8'h3B

// ==========================================================================
// Peripheral enable bit positions
`define PER_CONV_EN 0
`define PER_CMP_EN 1
`define PER_CMP_REF 2
`define PER_WDOG_EN 3

// ==========================================================================
// Mode encodings and reset values
`define MODE_IDLE 2'h0
`define MODE_NOISE 2'h1
`define MODE_PDOWN 2'h2
`define ISC_LEVEL 2'h0
`define RST_MCU_CTRL 8'h00
`define RST_DIG_DIS 8'h00
`define RST_PERIPH 8'h00

// ==========================================================================
// Timing and pin count
`define WAKE_STALL_CYC 4
`define PIN_COUNT 6

`endif

// ===== hw/sleep_pkg.sv
package sleep_pkg;
    // Sleep controller states, Gray coded along run-sleep-stall; stall to run flips both bits
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_STALL = 2'b11
    } sleep_state_e;

    typedef logic [1:0] mode_t;
endpackage : sleep_pkg

// ===== hw/sync3.sv
`timescale 1ns/1ps
// ==========================================================================
// Three-stage synchroniser; output changes once stages two and three agree
module sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // First stage feeds only the second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept per bit only on agreement, filters single-cycle glitches
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    dout[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : sync3

// ===== tb/sleep_ctrl_properties.sv
`timescale 1ns/1ps
`include "sleep_consts.svh"
// ======================================================================
// Port checks for the sleep controller
module sleep_ctrl_properties #(
    parameter int PINS = 6
) (
    // Clock, reset and stimulus
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic sleep_instr,
    input wire logic timer_irq,
    input wire logic ext_reset_req,
    input wire logic [PINS-1:0] pin_change_mask,
    input wire logic [1:0] brownout_level_fuses,
    // Design outputs
    input wire logic cpu_resume,
    input wire logic reset_vector_go,
    input wire logic clk_cpu_en,
    input wire logic clk_flash_en,
    input wire logic clk_io_en,
    input wire logic clk_conv_en,
    input wire logic osc_en,
    input wire logic conv_en,
    input wire logic conv_start,
    input wire logic wdog_en,
    input wire logic vref_en,
    input wire logic brownout_detector_en,
    input wire logic [PINS-1:0] in_buf_en
);
    logic [7:0] ctl_r;
    logic go;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Shadow of the control register, since its fields are internal
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= 8'h00;
        end else if (reg_wr && reg_addr == `OFF_MCU_CTRL) begin
            ctl_r <= reg_wdata;
        end
    end
    assign go = sleep_instr && clk_cpu_en && ctl_r[`MCU_ARM_BIT];

    property p_arm;
        sleep_instr && clk_cpu_en && (!ctl_r[5] || ctl_r[4:3] == 2'h3)
            |-> ##3 clk_cpu_en;
    endproperty
    a_arm: assert property (p_arm)
        else $error("sleep taken when refused");
    property p_idle;
        go && ctl_r[4:3] == 2'h0 |-> ##3
            (!clk_cpu_en && !clk_flash_en && clk_io_en && clk_conv_en);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle gating wrong");
    property p_noise;
        go && ctl_r[4:3] == 2'h1 |-> ##3 (!clk_cpu_en && !clk_flash_en
            && !clk_io_en && clk_conv_en && osc_en);
    endproperty
    a_noise: assert property (p_noise)
        else $error("noise gating wrong");
    property p_pdown;
        go && ctl_r[4:3] == 2'h2 |-> ##3 !(clk_cpu_en || clk_flash_en
            || clk_io_en || clk_conv_en || osc_en);
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("power-down gating wrong");
    property p_start;
        go && ctl_r[4:3] == 2'h1 && conv_en |-> ##[1:2] conv_start;
    endproperty
    a_start: assert property (p_start)
        else $error("no conversion on noise entry");
    property p_keep;
        $fell(clk_cpu_en) |-> conv_en == $past(conv_en, 2)
            && wdog_en == $past(wdog_en, 2);
    endproperty
    a_keep: assert property (p_keep)
        else $error("enable dropped on sleep");
    property p_buf;
        !clk_io_en && !clk_conv_en && !$past(clk_conv_en)
            |-> (in_buf_en & ~pin_change_mask & ~PINS'(2)) == '0;
    endproperty
    a_buf: assert property (p_buf)
        else $error("input buffer left on");
    property p_wake;
        $rose(timer_irq) && !clk_cpu_en && clk_io_en
            |-> !cpu_resume [*4] ##[1:12] cpu_resume;
    endproperty
    a_wake: assert property (p_wake)
        else $error("interrupt wake timing wrong");
    property p_rst;
        $rose(ext_reset_req) && !clk_cpu_en |-> ##[1:16] reset_vector_go;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset wake missing");
    property p_bod;
        $past(rstn) && $stable(brownout_level_fuses) |->
            brownout_detector_en == (brownout_level_fuses != 2'h3)
            && (brownout_level_fuses == 2'h3 || vref_en);
    endproperty
    a_bod: assert property (p_bod)
        else $error("detector or reference wrong");
endmodule : sleep_ctrl_properties

// ===== tb/conv_model.sv
`timescale 1ns/1ps
// ======================================================================
// Converter stand-in: a start is answered by a done level later
module conv_model #(
    parameter int LAT = 40
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Converter handshake
    input wire logic conv_start,
    output logic conv_done_irq
);
    int cnt;
    // Done held three cycles so a synchroniser cannot miss it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            conv_done_irq <= 1'b0;
        end else begin
            cnt <= conv_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
            conv_done_irq <= cnt > 0 && cnt < 4;
        end
    end
endmodule : conv_model

// ===== tb/sleep_ctrl_bench.sv
`timescale 1ns/1ps
`include "sleep_consts.svh"
`define CHK(a, b) begin \
    num_checks++; \
    if ((a) !== (b)) begin \
        err_total++; \
        $display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
    end \
end
// ======================================================================
// Bench top
module sleep_ctrl_bench;
    localparam int PINS = 6;
    logic core_clk, rstn, reg_wr, reg_rd, sleep_instr, ext_irq_zero;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [PINS-1:0] pin_change_mask, pin_in, in_buf_en;
    logic ext_reset_req, wdog_reset_req, bod_reset_req, cpu_resume;
    logic conv_done_irq, nvm_ready_irq, timer_irq, cmp_irq, wdog_irq;
    logic [1:0] brownout_level_fuses;
    logic clk_cpu_en, clk_flash_en, clk_io_en, clk_conv_en, osc_en;
    logic conv_en, conv_start, conv_extended, cmp_en, vref_en, wdog_en;
    logic reset_vector_go, brownout_detector_en, ext_irq_en;
    logic [15:0] seed;
    int err_total, num_checks, n_res, n_rvg;

    sleep_ctrl #(.PINS(PINS), .STARTUP_CYC(2)) DUT (.core_clk, .rstn,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_instr,
        .cpu_resume, .reset_vector_go, .ext_irq_zero, .pin_change_mask,
        .pin_in, .ext_reset_req, .wdog_reset_req, .bod_reset_req,
        .conv_done_irq, .nvm_ready_irq, .timer_irq, .cmp_irq, .wdog_irq,
        .brownout_level_fuses, .clk_cpu_en, .clk_flash_en, .clk_io_en,
        .clk_conv_en, .osc_en, .conv_en, .conv_start, .conv_extended,
        .cmp_en, .vref_en, .brownout_detector_en, .wdog_en, .ext_irq_en,
        .in_buf_en);
    conv_model #(.LAT(40)) far (.core_clk, .rstn, .conv_start,
        .conv_done_irq);

    // Clock at 50 ns
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Wake pulses counted, so a wait can see them after the fact
    always @(posedge core_clk) begin
        if (cpu_resume === 1'b1) n_res++;
        if (reset_vector_go === 1'b1) n_rvg++;
    end

    function automatic logic [15:0] xs(input logic [15:0] x);
        logic [15:0] y;
        y = x ^ (x << 7);
        y = y ^ (y >> 9);
        return y ^ (y << 8);
    endfunction : xs

    task automatic end_sim();
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask : rd

    // Control write then one sleep pulse; ends once gating has settled
    task automatic slp(input logic [7:0] ctl);
        wr(`OFF_MCU_CTRL, ctl);
        @(posedge core_clk);
        sleep_instr <= 1'b1;
        @(posedge core_clk);
        sleep_instr <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : slp

    // Bounded wait for one more pulse on the given counter
    task automatic wake(ref int cnt);
        int base;
        base = cnt;
        num_checks++;
        for (int i = 0; i < 60 && cnt == base; i++) @(posedge core_clk);
        if (cnt == base) begin
            err_total++;
            end_sim();
        end
        @(posedge core_clk);
    endtask : wake

    initial begin
        {rstn, reg_wr, reg_rd, sleep_instr, ext_reset_req} = 5'h00;
        {wdog_reset_req, bod_reset_req, nvm_ready_irq} = 3'h0;
        {timer_irq, cmp_irq, wdog_irq} = 3'h0;
        {reg_addr, reg_wdata, pin_in} = 18'h00000;
        ext_irq_zero = 1'b1;
        pin_change_mask = 6'h10;
        brownout_level_fuses = 2'h3;
        {err_total, num_checks, n_res, n_rvg} = '0;
        seed = 16'h4993;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        // Random register traffic, with an unmapped read each pass
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(`OFF_MCU_CTRL, seed[7:0]);
            rd(`OFF_MCU_CTRL, seed[7:0] & `MCU_CTRL_MASK);
            wr(`OFF_DIG_DIS, seed[15:8]);
            pin_in <= seed[5:0];
            rd(4'hF, 8'h00);
            `CHK(in_buf_en, ~seed[13:8])
        end
        wr(`OFF_DIG_DIS, 8'h00);
        slp(8'h08);
        `CHK(clk_cpu_en, 1'b1)
        slp(8'h38);
        `CHK(clk_cpu_en, 1'b1)
        // Idle: timer, comparator, watchdog and nvm-ready sources each wake
        for (int i = 0; i < 4; i++) begin
            slp(8'h20);
            `CHK({clk_cpu_en, clk_flash_en, clk_io_en, osc_en}, 4'h3)
            @(posedge core_clk);
            {timer_irq, cmp_irq, wdog_irq, nvm_ready_irq} <= 4'h8 >> i;
            wake(n_res);
            {timer_irq, cmp_irq, wdog_irq, nvm_ready_irq} <= 4'h0;
        end
        // Noise: timer and comparator ignored, conversion wakes
        wr(`OFF_PERIPH, 8'h09);
        slp(8'h28);
        `CHK({clk_io_en, clk_conv_en, conv_en, wdog_en}, 4'h7)
        `CHK(ext_irq_en, 1'b1)
        @(posedge core_clk);
        {timer_irq, cmp_irq} <= 2'h3;
        repeat (14) @(posedge core_clk);
        #1 `CHK(clk_cpu_en, 1'b0)
        @(posedge core_clk);
        {timer_irq, cmp_irq} <= 2'h0;
        wake(n_res);
        rd(`OFF_WAKE_CAUSE, 8'h11);
        `CHK(conv_extended, 1'b0)
        wr(`OFF_PERIPH, 8'h00);
        wr(`OFF_PERIPH, 8'h01);
        @(posedge core_clk);
        #1 `CHK(conv_extended, 1'b1)
        // Power-down, edge-type line ignored, each reset wakes
        for (int i = 0; i < 3; i++) begin
            wr(`OFF_PERIPH, 8'h0E);
            slp(8'h32);
            `CHK({osc_en, clk_conv_en, cmp_en, wdog_en, vref_en}, 5'h3)
            `CHK(in_buf_en, 6'h10)
            @(posedge core_clk);
            ext_irq_zero <= 1'b0;
            repeat (20) @(posedge core_clk);
            #1 `CHK(osc_en, 1'b0)
            @(posedge core_clk);
            {ext_reset_req, wdog_reset_req, bod_reset_req} <= 3'h4 >> i;
            ext_irq_zero <= 1'b1;
            wake(n_rvg);
            {ext_reset_req, wdog_reset_req, bod_reset_req} <= 3'h0;
        end
        // Power-down, low level then pin change wake; level held till then
        for (int i = 0; i < 2; i++) begin
            slp(8'h30);
            `CHK(in_buf_en, 6'h12)
            @(posedge core_clk);
            ext_irq_zero <= (i == 1);
            pin_in <= pin_in ^ (i == 1 ? 6'h10 : 6'h00);
            wake(n_res);
            ext_irq_zero <= 1'b1;
        end
        wr(`OFF_PERIPH, 8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            brownout_level_fuses <= 2'(i * 2 + 1);
            repeat (3) @(posedge core_clk);
            #1 `CHK({brownout_detector_en, vref_en}, {2{i == 0}})
        end
        end_sim();
    end
endmodule : sleep_ctrl_bench

bind sleep_ctrl sleep_ctrl_properties #(.PINS(PINS)) chk (.core_clk, .rstn,
    .reg_addr, .reg_wdata, .reg_wr, .sleep_instr, .timer_irq,
    .ext_reset_req, .pin_change_mask, .brownout_level_fuses, .cpu_resume,
    .reset_vector_go, .clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_conv_en,
    .osc_en, .conv_en, .conv_start, .wdog_en, .vref_en,
    .brownout_detector_en, .in_buf_en);
